// file: iop_map.svh
`ifndef IOP_MAP_SVH
`define IOP_MAP_SVH
`define IOP_ADDR_A_DATA  12'h000
`define IOP_ADDR_A_DIR   12'h004
`define IOP_ADDR_A_FUNC  12'h008
`define IOP_ADDR_B_DATA  12'h00c
`define IOP_ADDR_B_DIR   12'h010
`define IOP_ADDR_B_FUNC  12'h014
`define IOP_ADDR_STATUS  12'h018
`define IOP_A_DATA_RST   8'hff
`define IOP_A_DIR_RST    8'h00
`define IOP_A_FUNC_RST   8'h00
`define IOP_B_DIR_RST    8'h00
`define IOP_B_FUNC_RST   8'h00
`define IOP_B_DIR_USED   8'hfc
`define IOP_B_FUNC_USED  8'h77
`define IOP_B_FIXED_ONES 8'h83
`define IOP_B_STRAP_MASK 8'h7c
`define IOP_B_PUP_FUNC   8'h44
`define IOP_BIT_RD       0
`define IOP_BIT_WR       1
`define IOP_STRAP_SETTLE 3'd4
`endif

// file: iop_pin.sv
`timescale 1ns/100ps
// one general-purpose pin: direction picks latch drive or pin readback
module iop_pin (
  input  wire logic dir,
  input  wire logic latch,
  input  wire logic pin_sync,
  output logic      drive_oe,
  output logic      read_val
);
  assign drive_oe = dir;
  assign read_val = dir ? latch : pin_sync;
endmodule : iop_pin

// file: iop_pin_model.sv
`timescale 1ns/100ps
module iop_pin_model (
  input  wire logic [7:0] port_a_out,
  input  wire logic [7:0] port_a_oe,
  input  wire logic [7:0] port_b_out,
  input  wire logic [7:0] port_b_oe,
  input  wire logic [7:0] port_b_pullup,
  input  wire logic [7:0] ext_a,
  input  wire logic [7:0] ext_b,
  output logic      [7:0] port_a_in,
  output logic      [7:0] port_b_in
);
  // outside device is weak: an enabled pull-up wins over it
  assign port_a_in = (port_a_oe & port_a_out) | (~port_a_oe & ext_a);
  assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & (port_b_pullup | ext_b));
endmodule : iop_pin_model

// file: iop_pkg.sv
package iop_pkg;
  typedef logic [7:0] iop_byte_t;
  typedef enum logic [1:0] {
    IOP_IDLE   = 2'b00,
    IOP_ACCESS = 2'b01
  } iop_bus_state_t;
endpackage : iop_pkg

// file: iop_port_pair.sv
`timescale 1ns/100ps
`include "iop_map.svh"
module iop_port_pair (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  port_a_in,
  output logic      [7:0]  port_a_out,
  output logic      [7:0]  port_a_oe,
  input  wire logic [7:0]  port_b_in,
  output logic      [7:0]  port_b_out,
  output logic      [7:0]  port_b_oe,
  output logic      [7:0]  port_b_pullup,
  output logic      [7:0]  port_a_function,
  input  wire logic        reset_pullup_strap,
  input  wire logic        bus_acknowledge,
  input  wire logic        ext_read_strobe,
  input  wire logic        ext_write_strobe,
  input  wire logic        ext_area_access
);
  iop_pkg::iop_byte_t port_a_data;
  iop_pkg::iop_byte_t port_a_direction;
  iop_pkg::iop_byte_t port_b_data;
  iop_pkg::iop_byte_t port_b_direction;
  iop_pkg::iop_byte_t port_b_function;
  iop_pkg::iop_bus_state_t bus_state;
  logic [7:0]  a_sync;
  logic [7:0]  b_sync;
  logic [7:0]  a_read;
  logic [7:0]  b_read;
  logic [7:0]  a_oe_w;
  logic [7:0]  b_oe_w;
  logic        strap_sync;
  logic        strap_taken;
  logic        strap_lvl;
  logic [7:0]  next_port_b_out;
  logic [7:0]  next_port_b_oe;
  logic [7:0]  next_port_b_pullup;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic        wr_fire;
  logic        setup;
  logic        wr_a_data;
  logic        wr_a_dir;
  logic        wr_a_func;
  logic        wr_b_data;
  logic        wr_b_dir;
  logic        wr_b_func;
  logic [2:0]  settle_cnt;
  logic        strap_capture;

  // pins whose pull-up follows inverted bus acknowledge while their function bit is set
  localparam iop_pkg::iop_byte_t PUP_FUNC_PINS = `IOP_B_PUP_FUNC;

  iop_sync #(.WIDTH(8), .RST_VAL(8'hff)) u_sync_a (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (port_a_in),
    .sync_out (a_sync)
  );

  iop_sync #(.WIDTH(8), .RST_VAL(8'hff)) u_sync_b (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (port_b_in),
    .sync_out (b_sync)
  );

  // the strap is a pin, so it is synchronised and then caught once after reset
  iop_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_strap (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (reset_pullup_strap),
    .sync_out (strap_sync)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pins
      iop_pin u_pin_a (
        .dir      (port_a_direction[g]),
        .latch    (port_a_data[g]),
        .pin_sync (a_sync[g]),
        .drive_oe (a_oe_w[g]),
        .read_val (a_read[g])
      );
      iop_pin u_pin_b (
        .dir      (port_b_direction[g]),
        .latch    (port_b_data[g]),
        .pin_sync (b_sync[g]),
        .drive_oe (b_oe_w[g]),
        .read_val (b_read[g])
      );
    end
  endgenerate

  // zero-wait APB: setup then one access cycle
  assign setup   = psel && !penable;
  assign wr_fire = psel && penable && pwrite && (bus_state == iop_pkg::IOP_ACCESS);

  // one write strobe per register keeps every register block except port_b_data a plain enable
  assign wr_a_data = wr_fire && paddr == `IOP_ADDR_A_DATA;
  assign wr_a_dir  = wr_fire && paddr == `IOP_ADDR_A_DIR;
  assign wr_a_func = wr_fire && paddr == `IOP_ADDR_A_FUNC;
  assign wr_b_data = wr_fire && paddr == `IOP_ADDR_B_DATA;
  assign wr_b_dir  = wr_fire && paddr == `IOP_ADDR_B_DIR;
  assign wr_b_func = wr_fire && paddr == `IOP_ADDR_B_FUNC;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= iop_pkg::IOP_IDLE;
    end else if (clk_en) begin
      case (bus_state)
        iop_pkg::IOP_IDLE: begin
          if (setup) begin
            bus_state <= iop_pkg::IOP_ACCESS;
          end
        end
        iop_pkg::IOP_ACCESS: begin
          bus_state <= iop_pkg::IOP_IDLE;
        end
        default: begin
          bus_state <= iop_pkg::IOP_IDLE;
        end
      endcase
    end
  end

  // pready rises in the access cycle so every access takes exactly two edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= setup;
    end
  end

  // the error flag only ever travels with pready
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pslverr <= setup ? next_pslverr : 1'b0;
    end
  end

  // read data is zero outside its answer cycle so stale values never leak
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata <= (setup && !pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // write-only registers read as zero; unmapped addresses raise pslverr
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `IOP_ADDR_A_DATA: next_prdata = {24'h00_0000, a_read};
      `IOP_ADDR_A_DIR:  next_prdata = 32'h0000_0000;
      `IOP_ADDR_A_FUNC: next_prdata = 32'h0000_0000;
      `IOP_ADDR_B_DATA: next_prdata = {24'h00_0000, b_read};
      `IOP_ADDR_B_DIR:  next_prdata = 32'h0000_0000;
      `IOP_ADDR_B_FUNC: next_prdata = 32'h0000_0000;
      `IOP_ADDR_STATUS: next_prdata = {30'h0000_0000, bus_acknowledge, strap_lvl};
      default:          next_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_data <= `IOP_A_DATA_RST;
    end else if (clk_en && wr_a_data) begin
      port_a_data <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_direction <= `IOP_A_DIR_RST;
    end else if (clk_en && wr_a_dir) begin
      port_a_direction <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_function <= `IOP_A_FUNC_RST;
    end else if (clk_en && wr_a_func) begin
      port_a_function <= pwdata[7:0];
    end
  end

  // the strap synchroniser shows its reset value for the first edges after
  // release, so the strap is only believed once the count has run out
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 3'd0;
    end else if (clk_en && settle_cnt != `IOP_STRAP_SETTLE) begin
      settle_cnt <= settle_cnt + 3'd1;
    end
  end

  assign strap_capture = clk_en && !strap_taken && settle_cnt == `IOP_STRAP_SETTLE &&
                         bus_state == iop_pkg::IOP_IDLE;

  // strap level is held once taken so later strap motion is ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken <= 1'b0;
      strap_lvl   <= 1'b0;
    end else if (strap_capture) begin
      strap_taken <= 1'b1;
      strap_lvl   <= strap_sync;
    end
  end

  // fixed ones; strap-dependent bits loaded when the strap is caught
  // limitation: strap-high pull-ups on pins 2..6 come up a few edges after
  // release, and a write before the strap is caught is dropped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_data <= `IOP_B_FIXED_ONES;
    end else if (strap_capture) begin
      port_b_data <= `IOP_B_FIXED_ONES | (strap_sync ? `IOP_B_STRAP_MASK : 8'h00);
    end else if (clk_en && strap_taken && wr_b_data) begin
      port_b_data <= pwdata[7:0];
    end
  end

  // direction reset, unused bits 0 and 1 held at zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_direction <= `IOP_B_DIR_RST;
    end else if (clk_en && wr_b_dir) begin
      port_b_direction <= pwdata[7:0] & `IOP_B_DIR_USED;
    end
  end

  // function reset, unused bits 3 and 7 held at zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_function <= `IOP_B_FUNC_RST;
    end else if (clk_en && wr_b_func) begin
      port_b_function <= pwdata[7:0] & `IOP_B_FUNC_USED;
    end
  end

  // plain output from latch after reset
  always_comb begin
    next_port_b_out = port_b_data;
    // read strobe on pin 0, only in external area, active low
    if (port_b_function[`IOP_BIT_RD]) begin
      next_port_b_out[0] = !(ext_read_strobe && ext_area_access);
    end
    // write strobe on pin 1, only in external area, active low
    if (port_b_function[`IOP_BIT_WR]) begin
      next_port_b_out[1] = !(ext_write_strobe && ext_area_access);
    end
  end

  // direction bits 0 and 1 are never stored, so the override is the only source
  always_comb begin
    next_port_b_oe = b_oe_w;
    // pins 0 and 1 output only
    next_port_b_oe[1:0] = 2'b11;
  end

  // pins 0 and 1 have no pull-up since they always drive
  always_comb begin
    next_port_b_pullup = 8'h00;
    // inputs with latch one enable the pull-up
    for (int i = 2; i < 8; i++) begin
      next_port_b_pullup[i] = !port_b_direction[i] && port_b_data[i];
    end
    // pull-up on pins 2 and 6 in function mode while bus acknowledge is low
    for (int i = 2; i < 8; i++) begin
      if (PUP_FUNC_PINS[i] && port_b_function[i]) begin
        next_port_b_pullup[i] = !bus_acknowledge;
      end
    end
  end

  // every pin-side output is registered so pin timing does not depend on
  // the decode depth above
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_out <= `IOP_A_DATA_RST;
    end else if (clk_en) begin
      port_a_out <= port_a_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_oe <= `IOP_A_DIR_RST;
    end else if (clk_en) begin
      port_a_oe <= a_oe_w;
    end
  end

  // pins 0 and 1 come out of reset driving high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_out <= `IOP_B_FIXED_ONES;
    end else if (clk_en) begin
      port_b_out <= next_port_b_out;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_oe <= 8'h03;
    end else if (clk_en) begin
      port_b_oe <= next_port_b_oe;
    end
  end

  // pin 7 pull-up on from reset whatever the strap
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_b_pullup <= 8'h80;
    end else if (clk_en) begin
      port_b_pullup <= next_port_b_pullup;
    end
  end
endmodule : iop_port_pair

// file: iop_port_pair_properties.sv
`timescale 1ns/100ps
module iop_port_pair_properties (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [7:0]  port_a_out,
  input wire logic [7:0]  port_a_oe,
  input wire logic [7:0]  port_b_out,
  input wire logic [7:0]  port_b_oe,
  input wire logic [7:0]  port_b_pullup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic wa;
  logic wd;
  assign wa = psel && penable && pwrite && pready && paddr == 12'h004;
  assign wd = psel && penable && pwrite && pready && paddr == 12'h000;
  ready_setup_a: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  b_low_out_a: assert property (port_b_oe[1:0] == 2'b11)
    else $error("port b low pins not driven");
  // pin outputs follow the register one edge after the write edge
  a_dir_wr_a: assert property ($changed(port_a_oe) |-> $past(wa, 2) &&
    {24'h0, port_a_oe} == ($past(pwdata, 2) & 32'hff)) else $error("direction without write");
  a_latch_wr_a: assert property ($changed(port_a_out) |-> $past(wd, 2) &&
    {24'h0, port_a_out} == ($past(pwdata, 2) & 32'hff)) else $error("latch without write");
  // a lag of one edge between latch and pull-up is tolerated
  b_pullup_a: assert property ($stable(port_b_out) && $stable(port_b_oe) |->
    (port_b_pullup & 8'hb8) == (~port_b_oe & port_b_out & 8'hb8)) else $error("bad pull-up");
  cover property (wa);
  cover property (pslverr);
  cover property ($fell(port_b_pullup[2]));
endmodule : iop_port_pair_properties
bind iop_port_pair iop_port_pair_properties CHK (.*);

// file: iop_port_pair_tb_top.sv
`timescale 1ns/100ps
`include "iop_map.svh"
module iop_port_pair_tb_top;
  logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, reset_pullup_strap = 1'b1, bus_acknowledge = 1'b0;
  logic        ext_read_strobe = 1'b0, ext_write_strobe = 1'b0, ext_area_access = 1'b0;
  logic        pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe;
  logic [7:0]  port_b_pullup, port_a_function, ext_a = 8'h00, ext_b = 8'h00;
  int          error_cnt = 0, n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  iop_port_pair DUT (.*);
  iop_pin_model PINS (.*);
  task automatic report_and_stop;
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask : apb
  task automatic do_reset(input logic s);
    rst_n              <= 1'b0;
    reset_pullup_strap <= s;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    // strap is caught at the fifth edge, outputs show it one edge later
    repeat (8) @(posedge sys_clk);
  endtask : do_reset
  task automatic t_reset(input logic s);
    chk(port_a_out, 8'hff);
    chk(port_a_oe, 8'h00);
    chk(port_a_function, 8'h00);
    chk(port_b_out, s ? 8'hff : 8'h83);
    chk(port_b_oe, 8'h03);
    chk(port_b_pullup, s ? 8'hfc : 8'h80);
    apb(1'b0, `IOP_ADDR_A_DIR, 32'h0);
    chk(rd[7:0], 8'h00);
    apb(1'b0, `IOP_ADDR_STATUS, 32'h0);
    chk(rd[7:0], {7'h0, s});
  endtask : t_reset
  task automatic t_port_a;
    ext_a <= 8'hc3;
    apb(1'b1, `IOP_ADDR_A_DIR, 32'h0f);
    apb(1'b1, `IOP_ADDR_A_DATA, 32'h5a);
    repeat (4) @(posedge sys_clk);
    chk(port_a_oe, 8'h0f);
    chk(port_a_out, 8'h5a);
    apb(1'b0, `IOP_ADDR_A_DATA, 32'h0);
    chk(rd[7:0], 8'hca);
    apb(1'b1, `IOP_ADDR_A_FUNC, 32'h3c);
    repeat (2) @(posedge sys_clk);
    chk(port_a_function, 8'h3c);
    apb(1'b1, 12'h020, 32'h55);
    chk({7'h0, er}, 8'h01);
  endtask : t_port_a
  task automatic t_port_b;
    ext_b <= 8'ha5;
    apb(1'b1, `IOP_ADDR_B_DIR, 32'hff);
    repeat (2) @(posedge sys_clk);
    chk(port_b_oe, 8'hff);
    apb(1'b1, `IOP_ADDR_B_DIR, 32'h00);
    apb(1'b1, `IOP_ADDR_B_DATA, 32'h00);
    repeat (4) @(posedge sys_clk);
    chk(port_b_oe, 8'h03);
    apb(1'b0, `IOP_ADDR_B_DATA, 32'h0);
    chk(rd[7:0], 8'ha4);
  endtask : t_port_b
  task automatic t_strobes;
    logic [6:0] t [4];
    t = '{7'b11_0_11_11, 7'b11_1_10_10, 7'b11_1_01_01, 7'b00_1_11_11};
    apb(1'b1, `IOP_ADDR_B_DATA, 32'hff);
    foreach (t[i]) begin
      apb(1'b1, `IOP_ADDR_B_FUNC, {30'h0, t[i][6:5]});
      ext_area_access  <= t[i][4];
      ext_read_strobe  <= t[i][3];
      ext_write_strobe <= t[i][2];
      repeat (3) @(posedge sys_clk);
      chk({6'h0, port_b_out[1:0]}, {6'h0, t[i][1:0]});
    end
  endtask : t_strobes
  task automatic t_pullup;
    apb(1'b1, `IOP_ADDR_B_DATA, 32'h00);
    apb(1'b1, `IOP_ADDR_B_FUNC, 32'h44);
    repeat (3) @(posedge sys_clk);
    chk(port_b_pullup & 8'h44, 8'h44);
    bus_acknowledge <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(port_b_pullup & 8'h44, 8'h00);
    // clock enable low freezes the registered pull-ups
    clk_en          <= 1'b0;
    bus_acknowledge <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(port_b_pullup & 8'h44, 8'h00);
    clk_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(port_b_pullup & 8'h44, 8'h44);
  endtask : t_pullup
  initial begin
    do_reset(1'b1);
    t_reset(1'b1);
    do_reset(1'b0);
    t_reset(1'b0);
    t_port_a();
    t_port_b();
    t_strobes();
    t_pullup();
    report_and_stop();
  end
endmodule : iop_port_pair_tb_top

// file: iop_sync.sv
`timescale 1ns/100ps
// three-stage synchroniser; output moves only when stages two and three agree
module iop_sync #(
  parameter int          WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1   <= RST_VAL;
      stage2   <= RST_VAL;
      stage3   <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (clk_en) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule : iop_sync
